// >>> rtl/crcgen_pkg.sv
// Summary of operation
// - Software picks CCITT-16 or Ethernet-32 polynomial.
// - Result width follows polynomial: 16 or 32 bits.
// - DMA data items update checksum without processor.
// - Automatic run over whole flash or range.
// - Processor I/O writes fold into running checksum.
`default_nettype none
package crcgen_pkg;
    // ==========================================================
    // Polynomials, seeds and widths
    localparam logic [31:0] CRCGEN_POLY16 = 32'h0000_1021;
    localparam logic [31:0] CRCGEN_POLY32 = 32'h04c1_1db7;
    localparam logic [31:0] CRCGEN_SEED16 = 32'h0000_ffff;
    localparam logic [31:0] CRCGEN_SEED32 = 32'hffff_ffff;
    localparam logic [31:0] CRCGEN_MASK16 = 32'h0000_ffff;
    localparam int CRCGEN_DATA_W = 8;
    localparam int CRCGEN_ADDR_W = 17;
    localparam logic [16:0] CRCGEN_FLASH_LAST = 17'h1_ffff;

    // ==========================================================
    // Carrier types
    typedef enum logic [1:0] {
        CRCGEN_SRC_IO = 2'h0,
        CRCGEN_SRC_DMA = 2'h1,
        CRCGEN_SRC_FLASH = 2'h2
    } crcgen_src_t;

    typedef struct packed {
        logic valid;
        logic [CRCGEN_DATA_W-1:0] data;
    } crcgen_beat_t;

    typedef struct packed {
        logic start;
        logic whole;
        logic [CRCGEN_ADDR_W-1:0] first;
        logic [CRCGEN_ADDR_W-1:0] last;
    } crcgen_sweep_t;
endpackage
`default_nettype wire

// >>> rtl/crcgen_step.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// One byte folded into the remainder, msb first, no reflection.
module crcgen_step (
    input wire logic [31:0] crc_in,
    input wire logic [7:0] data,
    input wire logic wide,
    output logic [31:0] crc_out
);
    logic [31:0] stage [0:8];
    logic [31:0] poly;
    logic [4:0] top;

    assign poly = wide ? crcgen_pkg::CRCGEN_POLY32 : crcgen_pkg::CRCGEN_POLY16;
    assign top = wide ? 5'h1f : 5'h0f;
    assign stage[0] = crc_in;

    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_bit
            logic fb;
            logic [31:0] sh;
            assign fb = stage[i][top] ^ data[7-i];
            assign sh = {stage[i][30:0], 1'b0};
            assign stage[i+1] = (fb ? (sh ^ poly) : sh)
                & (wide ? 32'hffff_ffff : crcgen_pkg::CRCGEN_MASK16);
        end
    endgenerate

    assign crc_out = stage[8];
endmodule
`default_nettype wire

// >>> rtl/crcgen_top.sv
`timescale 1ns/10ps
`default_nettype none
module crcgen_top (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic cfg_wide,
    input wire logic cfg_reset,
    input wire logic [1:0] cfg_source,
    input wire crcgen_pkg::crcgen_beat_t io_beat,
    input wire crcgen_pkg::crcgen_beat_t dma_beat,
    input wire crcgen_pkg::crcgen_sweep_t sweep,
    output logic flash_rd,
    output logic [crcgen_pkg::CRCGEN_ADDR_W-1:0] flash_addr,
    input wire logic flash_ack,
    input wire logic [crcgen_pkg::CRCGEN_DATA_W-1:0] flash_data,
    output logic [31:0] checksum,
    output logic busy,
    output logic zero
);
    // ==========================================================
    // Sweep state machine
    typedef enum logic [1:0] {
        CRCGEN_IDLE = 2'b00,
        CRCGEN_REQ = 2'b01,
        CRCGEN_WAIT = 2'b10
    } crcgen_state_t;

    crcgen_state_t state_r, state_nxt;
    logic [crcgen_pkg::CRCGEN_ADDR_W-1:0] addr_r, addr_nxt, last_r, last_nxt;
    logic rd_r, rd_nxt;
    logic [31:0] crc_r, crc_nxt, stepped;
    logic zero_r, zero_nxt;
    logic wide_r, wide_nxt;
    logic busy_r, busy_nxt;
    logic fold;
    logic [7:0] fold_data;

    // Mode is latched on a clear so a mid-stream flip cannot corrupt width.
    always_comb begin
        state_nxt = state_r;
        addr_nxt = addr_r;
        last_nxt = last_r;
        rd_nxt = 1'b0;
        case (state_r)
            CRCGEN_IDLE: begin
                if (sweep.start && cfg_source == crcgen_pkg::CRCGEN_SRC_FLASH) begin
                    addr_nxt = sweep.whole ? '0 : sweep.first;
                    last_nxt = sweep.whole ? crcgen_pkg::CRCGEN_FLASH_LAST : sweep.last;
                    state_nxt = CRCGEN_REQ;
                end
            end
            CRCGEN_REQ: begin
                rd_nxt = 1'b1;
                state_nxt = CRCGEN_WAIT;
            end
            CRCGEN_WAIT: begin
                rd_nxt = !flash_ack;
                if (flash_ack) begin
                    if (addr_r == last_r) begin
                        state_nxt = CRCGEN_IDLE;
                    end else begin
                        addr_nxt = addr_r + 1'b1;
                        state_nxt = CRCGEN_REQ;
                    end
                end
            end
            default: begin
                state_nxt = CRCGEN_IDLE;
            end
        endcase
        busy_nxt = (state_nxt != CRCGEN_IDLE);
    end

    // ==========================================================
    // Source selection and fold
    always_comb begin
        fold = 1'b0;
        fold_data = io_beat.data;
        case (cfg_source)
            crcgen_pkg::CRCGEN_SRC_IO: begin
                fold = io_beat.valid;
                fold_data = io_beat.data;
            end
            crcgen_pkg::CRCGEN_SRC_DMA: begin
                fold = dma_beat.valid;
                fold_data = dma_beat.data;
            end
            crcgen_pkg::CRCGEN_SRC_FLASH: begin
                fold = (state_r == CRCGEN_WAIT) && flash_ack;
                fold_data = flash_data;
            end
            default: begin
                fold = 1'b0;
            end
        endcase
    end

    crcgen_step u_step (
        .crc_in(crc_r),
        .data(fold_data),
        .wide(wide_r),
        .crc_out(stepped)
    );

    always_comb begin
        wide_nxt = wide_r;
        crc_nxt = crc_r;
        if (cfg_reset) begin
            wide_nxt = cfg_wide;
            crc_nxt = cfg_wide ? crcgen_pkg::CRCGEN_SEED32 : crcgen_pkg::CRCGEN_SEED16;
        end else if (fold) begin
            crc_nxt = stepped;
        end
        zero_nxt = (crc_nxt == 32'h0000_0000);
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= CRCGEN_IDLE;
            addr_r <= '0;
            last_r <= '0;
            rd_r <= 1'b0;
            crc_r <= crcgen_pkg::CRCGEN_SEED16;
            wide_r <= 1'b0;
            zero_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            addr_r <= addr_nxt;
            last_r <= last_nxt;
            rd_r <= rd_nxt;
            crc_r <= crc_nxt;
            wide_r <= wide_nxt;
            zero_r <= zero_nxt;
            busy_r <= busy_nxt;
        end
    end

    // High half reads zero in 16-bit mode because the step masks it.
    assign checksum = crc_r;
    assign zero = zero_r;
    assign busy = busy_r;
    assign flash_rd = rd_r;
    assign flash_addr = addr_r;

    // ==========================================================
    // Sweep checks
    a_sweep_read: assert property (@(posedge ref_clk) disable iff (!arst_n)
        state_r == CRCGEN_REQ
        |=> flash_rd)
        else $error("no fetch issued");
    a_sweep_step: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (state_r == CRCGEN_WAIT && flash_ack && addr_r != last_r)
        |=> addr_r == $past(addr_r) + 1'b1)
        else $error("address not advanced");
    a_sweep_base: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (state_r == CRCGEN_IDLE && sweep.start && cfg_source == crcgen_pkg::CRCGEN_SRC_FLASH)
        |=> busy && addr_r == ($past(sweep.whole) ? '0 : $past(sweep.first)))
        else $error("sweep start address wrong");
    a_sweep_limit: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (state_r == CRCGEN_IDLE && sweep.start && cfg_source == crcgen_pkg::CRCGEN_SRC_FLASH)
        |=> last_r == ($past(sweep.whole) ? crcgen_pkg::CRCGEN_FLASH_LAST : $past(sweep.last)))
        else $error("sweep end address wrong");
    a_start_ignored: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (state_r != CRCGEN_IDLE && sweep.start)
        |=> $stable(last_r))
        else $error("start taken while busy");
    a_rd_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (state_r == CRCGEN_WAIT && !flash_ack)
        |=> flash_rd && $stable(flash_addr))
        else $error("fetch request not held");
    a_rd_drop: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (state_r == CRCGEN_WAIT && flash_ack)
        |=> !flash_rd)
        else $error("fetch request not released");
    a_sweep_end: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (state_r == CRCGEN_WAIT && flash_ack && addr_r == last_r)
        |=> !busy)
        else $error("sweep did not finish");
    a_idle_quiet: assert property (@(posedge ref_clk) disable iff (!arst_n)
        state_r == CRCGEN_IDLE
        |-> !flash_rd)
        else $error("fetch while idle");
    a_flash_fold: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (cfg_source == crcgen_pkg::CRCGEN_SRC_FLASH && state_r == CRCGEN_WAIT
            && flash_ack && !cfg_reset)
        |=> crc_r == $past(stepped))
        else $error("flash byte not folded");

    // ==========================================================
    // Checksum checks
    a_narrow_mask: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !wide_r
        |-> crc_r[31:16] == 16'h0000)
        else $error("high half set in 16-bit mode");
    a_zero_flag: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $rose(zero_r)
        |-> $past(fold) && !$past(cfg_reset))
        else $error("zero flag rose without a fold");
    a_zero_clear: assert property (@(posedge ref_clk) disable iff (!arst_n)
        cfg_reset
        |=> !zero_r)
        else $error("zero flag set after reseed");
    a_io_fold: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (cfg_source == crcgen_pkg::CRCGEN_SRC_IO && io_beat.valid && !cfg_reset)
        |=> crc_r == $past(stepped))
        else $error("io write not folded");
    a_dma_fold: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (cfg_source == crcgen_pkg::CRCGEN_SRC_DMA && dma_beat.valid && !cfg_reset)
        |=> crc_r == $past(stepped))
        else $error("dma item not folded");
    a_hold_idle: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (!fold && !cfg_reset)
        |=> $stable(crc_r))
        else $error("checksum moved");
    a_seed_sel: assert property (@(posedge ref_clk) disable iff (!arst_n)
        cfg_reset
        |=> wide_r == $past(cfg_wide))
        else $error("width not latched");
    a_reseed_val: assert property (@(posedge ref_clk) disable iff (!arst_n)
        cfg_reset
        |=> crc_r == ($past(cfg_wide) ? crcgen_pkg::CRCGEN_SEED32 : crcgen_pkg::CRCGEN_SEED16))
        else $error("wrong seed loaded");
    a_wide_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !cfg_reset
        |=> $stable(wide_r))
        else $error("width changed without reseed");
endmodule
`default_nettype wire

// >>> verification/crcgen_flash_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Flash stand-in: answers a read after wait_cyc idle cycles.
module crcgen_flash_model (
    input wire logic ref_clk,
    input wire logic rd,
    input wire logic [16:0] addr,
    input wire logic [3:0] wait_cyc,
    output logic ack,
    output logic [7:0] data
);
    logic [3:0] cnt_r = 4'h0;
    initial ack = 1'b0;
    initial data = 8'h00;
    always @(posedge ref_clk) begin
        if (rd && !ack && cnt_r >= wait_cyc) begin
            ack <= 1'b1;
            data <= addr[7:0] ^ 8'h5a;
            cnt_r <= 4'h0;
        end else begin
            ack <= 1'b0;
            // A released bus must not look like a held byte.
            data <= ~data;
            if (rd && !ack) cnt_r <= cnt_r + 4'h1;
        end
    end
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic ref_clk, arst_n, cfg_wide, cfg_reset, flash_rd, flash_ack, busy, zero;
    logic [1:0] cfg_source;
    logic [3:0] wait_cyc;
    logic [16:0] flash_addr;
    logic [7:0] flash_data;
    logic [31:0] checksum, exp;
    crcgen_pkg::crcgen_beat_t io_b, dma_b;
    crcgen_pkg::crcgen_sweep_t sw;
    int bad_count = 0, n_checks = 0, cyc = 0;
    crcgen_top dut (.ref_clk(ref_clk), .arst_n(arst_n), .cfg_wide(cfg_wide),
        .cfg_reset(cfg_reset), .cfg_source(cfg_source), .io_beat(io_b), .dma_beat(dma_b),
        .sweep(sw), .flash_rd(flash_rd), .flash_addr(flash_addr), .flash_ack(flash_ack),
        .flash_data(flash_data), .checksum(checksum), .busy(busy), .zero(zero));
    crcgen_flash_model fm (.ref_clk(ref_clk), .rd(flash_rd), .addr(flash_addr),
        .wait_cyc(wait_cyc), .ack(flash_ack), .data(flash_data));
    // ==========================================================
    // Reference fold, msb first, kept apart from the design's own.
    function automatic logic [31:0] fold(input logic [31:0] c, input logic [7:0] d,
        input logic w);
        logic fb;
        for (int i = 7; i >= 0; i--) begin
            fb = (w ? c[31] : c[15]) ^ d[i];
            c = {c[30:0], 1'b0};
            if (fb) c = c ^ (w ? crcgen_pkg::CRCGEN_POLY32 : crcgen_pkg::CRCGEN_POLY16);
        end
        return w ? c : c & crcgen_pkg::CRCGEN_MASK16;
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic summarize;
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic restart(input logic w, input logic [1:0] src);
        @(negedge ref_clk);
        cfg_source = src;
        cfg_wide = w;
        cfg_reset = 1'b1;
        @(negedge ref_clk);
        cfg_reset = 1'b0;
        exp = w ? crcgen_pkg::CRCGEN_SEED32 : crcgen_pkg::CRCGEN_SEED16;
        @(negedge ref_clk);
        chk(checksum, exp);
    endtask
    // The unselected source gets a different byte, so a leak shows.
    task automatic put(input logic [7:0] d);
        @(negedge ref_clk);
        io_b = '{1'b1, cfg_source == 2'h0 ? d : ~d};
        dma_b = '{1'b1, cfg_source == 2'h1 ? d : ~d};
        exp = fold(exp, d, cfg_wide);
    endtask
    task automatic idle;
        @(negedge ref_clk);
        io_b = '0;
        dma_b = '0;
        @(negedge ref_clk);
    endtask
    task automatic app;
        logic [31:0] e;
        e = exp;
        for (int i = (cfg_wide ? 3 : 1); i >= 0; i--) put(e[8*i+:8]);
        idle;
        chk(checksum, 32'h0);
        chk({31'h0, zero}, 32'h1);
    endtask
    task automatic t_io;
        restart(1'b0, 2'h0);
        for (int i = 0; i < 9; i++) put(8'h31 + 8'(i));
        idle;
        chk(checksum, exp);
        chk({31'h0, zero}, 32'h0);
        app;
        $display("test io16 done");
    endtask
    task automatic t_dma;
        restart(1'b1, 2'h1);
        for (int i = 0; i < 6; i++) put(8'(i * 17));
        idle;
        chk(checksum, exp);
        app;
        $display("test dma32 done");
    endtask
    task automatic t_flash;
        restart(1'b1, 2'h2);
        wait_cyc = 4'h2;
        @(negedge ref_clk);
        sw = '{1'b1, 1'b0, 17'h10, 17'h13};
        @(negedge ref_clk);
        sw.start = 1'b0;
        @(negedge ref_clk);
        sw = '{1'b1, 1'b1, 17'h0, 17'h1};
        @(negedge ref_clk);
        sw.start = 1'b0;
        for (int i = 16; i < 20; i++) exp = fold(exp, 8'(i) ^ 8'h5a, 1'b1);
        for (int i = 0; i < 200 && busy !== 1'b0; i++) @(negedge ref_clk);
        chk(checksum, exp);
        chk({15'h0, flash_addr}, 32'h13);
        chk({31'h0, busy}, 32'h0);
        $display("test flash range done");
    endtask
    task automatic t_whole;
        restart(1'b0, 2'h2);
        wait_cyc = 4'h0;
        @(negedge ref_clk);
        sw = '{1'b1, 1'b1, 17'h10, 17'h13};
        @(negedge ref_clk);
        sw.start = 1'b0;
        for (int i = 0; i < 4; i++) exp = fold(exp, 8'(i) ^ 8'h5a, 1'b0);
        repeat (12) @(negedge ref_clk);
        chk(checksum, exp);
        chk({15'h0, flash_addr}, 32'h4);
        arst_n = 1'b0;
        @(negedge ref_clk);
        arst_n = 1'b1;
        chk({29'h0, busy, flash_rd, zero}, 32'h0);
        chk(checksum, crcgen_pkg::CRCGEN_SEED16);
        $display("test flash whole done");
    endtask
    task automatic t_none;
        restart(1'b0, 2'h3);
        sw = '{1'b1, 1'b1, 17'h0, 17'h0};
        put(8'ha5);
        sw.start = 1'b0;
        put(8'h5a);
        idle;
        chk(checksum, crcgen_pkg::CRCGEN_SEED16);
        chk({30'h0, busy, zero}, 32'h0);
        $display("test no source done");
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            summarize;
        end
    end
    initial begin
        arst_n = 1'b0;
        {cfg_wide, cfg_reset, cfg_source, wait_cyc, exp} = '0;
        io_b = '0;
        dma_b = '0;
        sw = '0;
        repeat (16) @(negedge ref_clk);
        arst_n = 1'b1;
        t_io;
        t_dma;
        t_flash;
        t_whole;
        t_none;
        summarize;
    end
endmodule
`default_nettype wire
